// File: logic/dqu_top.sv
`timescale 1ns/1ps
`include "dqu_cfg.svh"

// Notes on behaviour
// - write-input with load pin low updates input and output register together.
// - with load pin high, a later falling edge transfers input to output.
// - mask command ignores address, loads mask from low four data bits.
// - mask bit 3 is channel D down to bit 0 for channel A.
// - mask resets to zero, so every channel follows the load pin.
// - masked channel ignores every load pin transition.
// - each load pin falling edge copies unmasked input registers to outputs.
// - load pin held low makes the mask irrelevant.
// - update command copies input to output, input unchanged.
// - write-and-update loads new data into input and output register.
// - reset pin low clears to zero or midscale; host holds 30 ns.
// - after reset pin release the cleared code holds until reprogrammed.
// - while reset pin is low no update reaches the outputs.
// - software reset returns to the power-on code.
// - load pin activity during power-on reset is ignored.
// - reset pin low at power-up defers initialisation until release.
// - power-up code is zero or midscale by select pin, held until write.
// - each write is address, command, data msb, data lsb, all acknowledged.
// - two register banks per channel; only the output bank drives the code.
// - command in top nibble, address bits next, then sixteen data bits.
module dqu_top #(
    parameter logic [6:0] DEV_ADDR = `DQU_DEV_ADDR
) (
    input wire logic CLOCK_I, // system clock, 200 MHz
    input wire logic RSTN_I, // power-on reset, sync, active low
    input wire logic SCL_I, // serial clock, link domain
    input wire logic SDA_I, // serial data pin level
    output logic SDA_O, // serial data drive value
    output logic SDA_OE_O, // serial data drive enable
    input wire logic LOAD_DAC_N_I, // load pin, active low
    input wire logic RESET_N_I, // hardware reset pin, active low
    input wire logic RESET_LEVEL_SELECT_I, // 0 zero scale, 1 midscale
    output logic [15:0] DAC_A_CODE_O, // channel A output code
    output logic [15:0] DAC_B_CODE_O, // channel B output code
    output logic [15:0] DAC_C_CODE_O, // channel C output code
    output logic [15:0] DAC_D_CODE_O // channel D output code
);

    // ----------------------------------------------------------------
    // constants and state
    // ----------------------------------------------------------------
    localparam int NCH = 4;
    localparam logic [3:0] RST_CYC = 4'(`DQU_RST_MIN_CYC);
    // sync order: ack, scl, sda, word toggle, level select, reset pin, load pin
    localparam logic [6:0] SYNC_RST = 7'h31;

    typedef struct packed {
        dqu_pkg::dqu_state_t st;
        logic [NCH-1:0][15:0] inreg;
        logic [NCH-1:0][15:0] dac;
        logic [NCH-1:0] mask;
        logic load_dac_n_prev;
        logic tgl_prev;
        logic sda_prev;
        logic frame;
        logic clr;
        logic link_rst;
        logic [3:0] rst_cnt;
        logic sda_oe;
    } dqu_top_st_t;

    dqu_top_st_t q;
    dqu_top_st_t d;

    logic [6:0] sync_lvl;
    logic oe_s;
    logic scl_s;
    logic sda_s;
    logic tgl_s;
    logic reset_level_select_s;
    logic hw_n_s;
    logic load_dac_n_s;
    logic [23:0] link_word;
    logic link_tgl;
    logic link_oe;

    logic evt;
    logic run_ok;
    logic load_dac_n_fall;
    logic start_c;
    logic stop_c;
    logic [3:0] cmd;
    logic [NCH-1:0] addr;
    logic [15:0] data;
    logic [15:0] clr_code;

    // ----------------------------------------------------------------
    // pin synchronisers and link receiver
    // ----------------------------------------------------------------
    // every input pin but clock and power-on reset, and the word toggle, pass four flops, the last one a filter on stages two and three
    dqu_sync #(
        .W(7),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .clk_i(CLOCK_I),
        .rst_n_i(RSTN_I),
        .d_i({link_oe, SCL_I, SDA_I, link_tgl, RESET_LEVEL_SELECT_I, RESET_N_I, LOAD_DAC_N_I}),
        .lvl_o(sync_lvl)
    );

    // byte framing runs on the serial clock itself
    dqu_link #(
        .DEV_ADDR(DEV_ADDR)
    ) u_link (
        .scl_i(SCL_I),
        .clr_i(q.clr),
        .rst_i(q.link_rst),
        .sda_i(SDA_I),
        .sda_oe_o(link_oe),
        .word_o(link_word),
        .word_tgl_o(link_tgl)
    );

    // named views of the synchronised levels
    assign oe_s = sync_lvl[6];
    assign scl_s = sync_lvl[5];
    assign sda_s = sync_lvl[4];
    assign tgl_s = sync_lvl[3];
    assign reset_level_select_s = sync_lvl[2];
    assign hw_n_s = sync_lvl[1];
    assign load_dac_n_s = sync_lvl[0];

    // ----------------------------------------------------------------
    // decode of events and word fields
    // ----------------------------------------------------------------
    // the word is held still by the link until the next one, so reading
    // it once the toggle has crossed is safe
    always_comb begin
        evt = (tgl_s != q.tgl_prev);
        cmd = link_word[`DQU_CMD_HI:`DQU_CMD_LO];
        addr = link_word[`DQU_ADDR_HI:`DQU_ADDR_LO];
        data = link_word[`DQU_DATA_HI:`DQU_DATA_LO];
        load_dac_n_fall = q.load_dac_n_prev && !load_dac_n_s;
        run_ok = (q.st == dqu_pkg::DQU_ST_RUN) && hw_n_s;
        start_c = scl_s && q.sda_prev && !sda_s;
        stop_c = scl_s && !q.sda_prev && sda_s;
        clr_code = reset_level_select_s ? `DQU_CODE_MID : `DQU_CODE_ZERO;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        d.load_dac_n_prev = load_dac_n_s;
        d.tgl_prev = tgl_s;
        d.sda_prev = sda_s;
        d.link_rst = 1'b0;
        d.sda_oe = oe_s;
        // start pulses the frame clear while scl is high, well before
        // the first data edge; idle keeps it held
        if (start_c) begin
            d.frame = 1'b1;
        end else if (stop_c) begin
            d.frame = 1'b0;
        end
        d.clr = start_c || !d.frame;
        // low time of the reset pin, saturating
        if (!hw_n_s) begin
            d.rst_cnt = (q.rst_cnt == RST_CYC) ? q.rst_cnt : q.rst_cnt + 4'h1;
        end else begin
            d.rst_cnt = 4'h0;
        end
        unique case (q.st)
            dqu_pkg::DQU_ST_INIT: begin
                // load pin and words are dropped until init completes
                if (hw_n_s) begin
                    for (int i = 0; i < NCH; i++) begin
                        d.inreg[i] = clr_code;
                        d.dac[i] = clr_code;
                    end
                    d.mask = `DQU_MASK_RST;
                    d.st = dqu_pkg::DQU_ST_RUN;
                end
            end
            dqu_pkg::DQU_ST_RUN: begin
                if (!hw_n_s) begin
                    // no updates while low; clear once held long enough
                    if (q.rst_cnt >= RST_CYC - 4'h1) begin
                        for (int i = 0; i < NCH; i++) begin
                            d.inreg[i] = clr_code;
                            d.dac[i] = clr_code;
                        end
                    end
                end else begin // release reloads nothing, cleared code holds
                    // falling load edge first; a command in the same cycle wins
                    if (load_dac_n_fall) begin
                        for (int i = 0; i < NCH; i++) begin
                            if (!q.mask[i]) begin
                                d.dac[i] = q.inreg[i];
                            end
                        end
                    end
                    if (evt) begin
                        unique case (cmd)
                            `DQU_CMD_WR_IN: begin
                                for (int i = 0; i < NCH; i++) begin
                                    if (addr[i]) begin
                                        d.inreg[i] = data;
                                        // pin low: straight through, mask ignored
                                        if (!load_dac_n_s) begin
                                            d.dac[i] = data;
                                        end
                                    end
                                end
                            end
                            `DQU_CMD_UPD: begin
                                for (int i = 0; i < NCH; i++) begin
                                    if (addr[i]) begin
                                        d.dac[i] = q.inreg[i];
                                    end
                                end
                            end
                            `DQU_CMD_WR_UPD: begin
                                for (int i = 0; i < NCH; i++) begin
                                    if (addr[i]) begin
                                        d.inreg[i] = data;
                                        d.dac[i] = data;
                                    end
                                end
                            end
                            `DQU_CMD_MASK: begin
                                d.mask = data[3:0];
                            end
                            `DQU_CMD_SWRST: begin
                                d.st = dqu_pkg::DQU_ST_INIT;
                                d.mask = `DQU_MASK_RST;
                            end
                            default: begin
                                // other codes belong to other functions
                            end
                        endcase
                    end
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            q <= '0;
            q.st <= dqu_pkg::DQU_ST_INIT;
            q.load_dac_n_prev <= 1'b1;
            q.sda_prev <= 1'b1;
            q.clr <= 1'b1;
            q.link_rst <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // only the output bank reaches the pins
    assign DAC_A_CODE_O = q.dac[0];
    assign DAC_B_CODE_O = q.dac[1];
    assign DAC_C_CODE_O = q.dac[2];
    assign DAC_D_CODE_O = q.dac[3];
    assign SDA_OE_O = q.sda_oe;
    assign SDA_O = 1'b0; // open drain, only ever pulls low

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!RSTN_I);

    instant_write_a: assert property (
        evt && run_ok && cmd == `DQU_CMD_WR_IN && addr[0] && !load_dac_n_s
        |=> q.dac[0] == $past(data) && q.inreg[0] == $past(data))
        else $error("write with load low did not reach output");

    mask_load_a: assert property (
        evt && run_ok && cmd == `DQU_CMD_MASK |=> q.mask == $past(data[3:0]))
        else $error("mask not loaded from low data bits");

    masked_hold_a: assert property (
        run_ok && load_dac_n_fall && q.mask[0] && !evt |=> $stable(q.dac[0]))
        else $error("masked channel followed load edge");

    load_edge_a: assert property (
        run_ok && load_dac_n_fall && !q.mask[2] && !evt |=> q.dac[2] == $past(q.inreg[2]))
        else $error("unmasked channel missed load edge");

    update_cmd_a: assert property (
        evt && run_ok && cmd == `DQU_CMD_UPD && addr[2]
        |=> q.dac[2] == $past(q.inreg[2]) && $stable(q.inreg[2]))
        else $error("update command wrong");

    write_update_a: assert property (
        evt && run_ok && cmd == `DQU_CMD_WR_UPD && addr[0]
        |=> q.dac[0] == $past(data) && q.inreg[0] == $past(data))
        else $error("write and update wrong");

    hw_clear_a: assert property (
        q.st == dqu_pkg::DQU_ST_RUN && !hw_n_s && q.rst_cnt == RST_CYC
        |=> q.dac[1] == $past(clr_code))
        else $error("reset pin did not clear output");

    reset_block_a: assert property (
        !hw_n_s && q.rst_cnt == RST_CYC ##1 !hw_n_s |=> $stable(q.dac))
        else $error("output changed under reset pin");

    swreset_a: assert property (
        evt && run_ok && cmd == `DQU_CMD_SWRST
        |=> q.st == dqu_pkg::DQU_ST_INIT && q.mask == 4'h0)
        else $error("software reset not taken");

    init_defer_a: assert property (
        q.st == dqu_pkg::DQU_ST_INIT && !hw_n_s |=> q.st == dqu_pkg::DQU_ST_INIT)
        else $error("init ran with reset pin low");

endmodule : dqu_top

// File: include/dqu_cfg.svh
`ifndef DQU_CFG_SVH
`define DQU_CFG_SVH

// ----------------------------------------------------------------
// command codes, top nibble of the 24-bit word
// ----------------------------------------------------------------
`define DQU_CMD_WR_IN 4'h1
`define DQU_CMD_UPD 4'h2
`define DQU_CMD_WR_UPD 4'h3
`define DQU_CMD_MASK 4'h5
`define DQU_CMD_SWRST 4'h6

// ----------------------------------------------------------------
// field positions in the 24-bit word
// ----------------------------------------------------------------
`define DQU_CMD_HI 23
`define DQU_CMD_LO 20
`define DQU_ADDR_HI 19
`define DQU_ADDR_LO 16
`define DQU_DATA_HI 15
`define DQU_DATA_LO 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DQU_CODE_ZERO 16'h0000
`define DQU_CODE_MID 16'h8000
`define DQU_MASK_RST 4'h0
`define DQU_DEV_ADDR 7'h0C

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DQU_CLK_NS 5
`define DQU_RST_MIN_NS 30
`define DQU_RST_MIN_CYC ((`DQU_RST_MIN_NS + `DQU_CLK_NS - 1) / `DQU_CLK_NS)

`endif

// File: include/dqu_pkg.sv
package dqu_pkg;

    // init waits for the reset pin, run serves commands and load edges
    typedef enum logic [0:0] {
        DQU_ST_INIT,
        DQU_ST_RUN
    } dqu_state_t;

endpackage : dqu_pkg

// File: logic/dqu_sync.sv
`timescale 1ns/1ps

module dqu_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i, // system clock
    input wire logic rst_n_i, // synchronous reset, active low
    input wire logic [W-1:0] d_i, // asynchronous inputs
    output logic [W-1:0] lvl_o // filtered levels
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } dqu_sync_st_t;

    dqu_sync_st_t q;
    dqu_sync_st_t d;
    logic [W-1:0] agree;

    // a level only moves once stages two and three agree
    always_comb begin
        agree = ~(q.s2 ^ q.s3);
        d = q;
        d.s1 = d_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.lvl = (q.s2 & agree) | (q.lvl & ~agree);
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            q <= d;
        end
    end

    assign lvl_o = q.lvl;

endmodule : dqu_sync

// File: logic/dqu_link.sv
`timescale 1ns/1ps
`include "dqu_cfg.svh"

module dqu_link #(
    parameter logic [6:0] DEV_ADDR = `DQU_DEV_ADDR
) (
    input wire logic scl_i, // serial clock, link domain
    input wire logic clr_i, // frame clear, active high, async
    input wire logic rst_i, // word clear, active high, async
    input wire logic sda_i, // serial data in
    output logic sda_oe_o, // pull data low (acknowledge)
    output logic [23:0] word_o, // last complete word
    output logic word_tgl_o // flips once per word
);

    typedef struct packed {
        logic [6:0] sh;
        logic [3:0] bits;
        logic [1:0] idx;
        logic hit;
        logic [15:0] part;
    } dqu_link_fr_t;

    typedef struct packed {
        logic [23:0] word;
        logic tgl;
    } dqu_link_wd_t;

    dqu_link_fr_t fq;
    dqu_link_fr_t fn;
    dqu_link_wd_t wq;
    dqu_link_wd_t wn;
    logic [7:0] byte_v;
    logic ack_q;

    // ----------------------------------------------------------------
    // bit and byte framing
    // ----------------------------------------------------------------
    // address byte, command byte, msb, lsb; extra bytes start a new word
    always_comb begin
        fn = fq;
        wn = wq;
        byte_v = {fq.sh, sda_i};
        if (fq.bits == 4'h8) begin
            fn.bits = 4'h0;
            fn.idx = (fq.idx == 2'h3) ? 2'h1 : fq.idx + 2'h1;
        end else begin
            fn.sh = byte_v[6:0];
            fn.bits = fq.bits + 4'h1;
            if (fq.bits == 4'h7) begin
                unique case (fq.idx)
                    2'h0: fn.hit = (byte_v[7:1] == DEV_ADDR) && !byte_v[0];
                    2'h1: fn.part[15:8] = byte_v;
                    2'h2: fn.part[7:0] = byte_v;
                    2'h3: begin
                        if (fq.hit) begin
                            wn.word = {fq.part, byte_v};
                            wn.tgl = ~wq.tgl;
                        end
                    end
                endcase
            end
        end
    end

    // frame state cleared by start and stop, seen from the system side
    always_ff @(posedge scl_i or posedge clr_i) begin
        if (clr_i) begin
            fq <= '0;
        end else begin
            fq <= fn;
        end
    end

    // word stays still until the next word, so the far side may read it
    always_ff @(posedge scl_i or posedge rst_i) begin
        if (rst_i) begin
            wq <= '0;
        end else begin
            wq <= wn;
        end
    end

    // acknowledge driven through the low phase around the ninth clock
    always_ff @(negedge scl_i or posedge clr_i) begin
        if (clr_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (fq.bits == 4'h8) && fq.hit;
        end
    end

    assign sda_oe_o = ack_q;
    assign word_o = wq.word;
    assign word_tgl_o = wq.tgl;

endmodule : dqu_link

// File: tb/dqu_i2c_mst.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// serial bus master model, write frames only
// ----------------------------------------------------------------
// scl is paced by q, slow enough for start and stop to cross the pin synchroniser
module dqu_i2c_mst #(
    parameter realtime Q = 40.0
) (
    input wire logic sda_i, // resolved data wire
    output logic scl_o, // serial clock, high when idle
    output logic sda_drv_o // 1 pulls the data wire low
);
    initial begin
        scl_o = 1'b1;
        sda_drv_o = 1'b0;
    end

    // one data bit, changed only while the clock is low
    task automatic put_bit(input logic b);
        sda_drv_o = ~b;
        #(Q) scl_o = 1'b1;
        #(2*Q) scl_o = 1'b0;
        #(Q);
    endtask : put_bit

    // eight bits msb first, then release and sample the acknowledge
    task automatic put_byte(input logic [7:0] v, output logic ack);
        for (int i = 7; i >= 0; i--) put_bit(v[i]);
        sda_drv_o = 1'b0;
        #(Q) scl_o = 1'b1;
        #(Q) ack = ~sda_i;
        #(Q) scl_o = 1'b0;
        #(Q);
    endtask : put_byte

    // address, command, data msb, data lsb between start and stop
    task automatic frame(input logic [7:0] ab, input logic [23:0] w, output logic [3:0] acks);
        sda_drv_o = 1'b1;
        #(Q) scl_o = 1'b0;
        #(Q);
        put_byte(ab, acks[3]);
        put_byte(w[23:16], acks[2]);
        put_byte(w[15:8], acks[1]);
        put_byte(w[7:0], acks[0]);
        sda_drv_o = 1'b1;
        #(Q) scl_o = 1'b1;
        #(Q) sda_drv_o = 1'b0;
        #(5*Q); // bus free time before any next start
    endtask : frame
endmodule : dqu_i2c_mst

// File: tb/test_quad_dac_update_control.sv
`timescale 1ns/1ps
`include "dqu_cfg.svh"
module test_quad_dac_update_control;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ld_n = 1'b1;
    logic hr_n = 1'b0;
    logic sel = 1'b1;
    logic scl, drv, sda_w, sda_o, sda_oe;
    logic [15:0] code_a, code_b, code_c, code_d, v;
    logic [15:0] inp[4];
    logic [15:0] dac[4];
    logic [3:0] mask;
    logic [31:0] rnd = 32'd17357;
    int n_mismatch = 0;
    int total_checks = 0;

    // ----------------------------------------------------------------
    // clock, wire and instances
    // ----------------------------------------------------------------
    always #2.5 clk = ~clk;
    // open drain wire with pull-up
    assign sda_w = ~drv & ~(sda_oe & ~sda_o);

    dqu_top dut_u (.CLOCK_I(clk), .RSTN_I(rst_n), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o),
        .SDA_OE_O(sda_oe), .LOAD_DAC_N_I(ld_n), .RESET_N_I(hr_n), .RESET_LEVEL_SELECT_I(sel),
        .DAC_A_CODE_O(code_a), .DAC_B_CODE_O(code_b), .DAC_C_CODE_O(code_c),
        .DAC_D_CODE_O(code_d));
    dqu_i2c_mst mst_u (.sda_i(sda_w), .scl_o(scl), .sda_drv_o(drv));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic void nxt(output logic [15:0] r);
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        r = rnd[15:0];
    endfunction : nxt

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    function automatic logic [15:0] clr_code(input logic s);
        return s ? `DQU_CODE_MID : `DQU_CODE_ZERO;
    endfunction : clr_code

    task automatic chk_dacs(input string t);
        repeat (20) @(posedge clk);
        #1;
        chk("dac a", dac[0], code_a);
        chk("dac b", dac[1], code_b);
        chk("dac c", dac[2], code_c);
        chk("dac d", dac[3], code_d);
        $display("test %s done", t);
    endtask : chk_dacs

    task automatic clear_all();
        for (int i = 0; i < 4; i++) begin
            inp[i] = clr_code(sel);
            dac[i] = clr_code(sel);
        end
    endtask : clear_all

    // expected effect of one accepted word on the bench copy
    task automatic model(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
        if (!hr_n) return;
        for (int i = 0; i < 4; i++) begin
            if (a[i] && (c == `DQU_CMD_WR_IN || c == `DQU_CMD_WR_UPD)) inp[i] = d;
            if (a[i] && (c == `DQU_CMD_WR_UPD || (c == `DQU_CMD_WR_IN && !ld_n))) dac[i] = d;
            if (a[i] && c == `DQU_CMD_UPD) dac[i] = inp[i];
        end
        if (c == `DQU_CMD_MASK) mask = d[3:0];
        if (c == `DQU_CMD_SWRST) begin
            clear_all();
            mask = `DQU_MASK_RST;
        end
    endtask : model

    task automatic word(input logic [6:0] da, input logic [3:0] c, input logic [3:0] a,
                        input logic [15:0] d);
        logic [3:0] acks;
        @(posedge clk) #1;
        mst_u.frame({da, 1'b0}, {c, a, d}, acks);
        chk("acks", (da == `DQU_DEV_ADDR) ? 16'h000F : 16'h0000, {12'h000, acks});
        chk("sda drive", 16'h0000, {15'h0000, sda_o});
        if (da == `DQU_DEV_ADDR) model(c, a, d);
    endtask : word

    // a falling load edge copies every unmasked input register
    task automatic set_ld(input logic lv);
        @(posedge clk) #1 ld_n = lv;
        repeat (10) @(posedge clk);
        if (!lv && hr_n) for (int i = 0; i < 4; i++) if (!mask[i]) dac[i] = inp[i];
    endtask : set_ld

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    // ----------------------------------------------------------------
    // watchdog, sized well above the expected run of about 150 us
    // ----------------------------------------------------------------
    initial begin
        #400us;
        n_mismatch++;
        give_verdict();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        for (int i = 0; i < 4; i++) dac[i] = 16'h0000;
        mask = `DQU_MASK_RST;
        repeat (2) @(posedge clk);
        #1 ld_n = 1'b0; // load activity during power-on reset
        repeat (2) @(posedge clk);
        #1 ld_n = 1'b1;
        rst_n = 1'b1;
        chk_dacs("init deferred");
        @(posedge clk) #1 hr_n = 1'b1;
        clear_all();
        chk_dacs("power-up code");
        nxt(v);
        word(`DQU_DEV_ADDR ^ 7'h01, `DQU_CMD_WR_UPD, 4'h1, v);
        chk_dacs("foreign address");
        for (int i = 0; i < 4; i++) begin
            nxt(v);
            word(`DQU_DEV_ADDR, `DQU_CMD_WR_IN, 4'h1 << i, v);
        end
        chk_dacs("deferred write held");
        set_ld(1'b0);
        set_ld(1'b1);
        chk_dacs("load edge");
        nxt(v);
        word(`DQU_DEV_ADDR, `DQU_CMD_MASK, v[15:12], {v[15:4], 4'h5});
        for (int i = 0; i < 4; i++) begin
            nxt(v);
            word(`DQU_DEV_ADDR, `DQU_CMD_WR_IN, 4'h1 << i, v);
        end
        set_ld(1'b0);
        set_ld(1'b1);
        chk_dacs("masked a and c");
        word(`DQU_DEV_ADDR, `DQU_CMD_UPD, 4'h4, 16'h0000);
        chk_dacs("update c");
        set_ld(1'b0);
        nxt(v);
        word(`DQU_DEV_ADDR, `DQU_CMD_WR_IN, 4'h1, v);
        chk_dacs("load held low");
        set_ld(1'b1);
        for (int k = 0; k < 6; k++) begin
            nxt(v);
            // channel A always in, so every random word reaches a checked channel
            word(`DQU_DEV_ADDR, (k % 2) ? `DQU_CMD_UPD : `DQU_CMD_WR_UPD, v[3:0] | 4'h1,
                 v ^ 16'h5A5A);
            chk_dacs("random word");
        end
        word(`DQU_DEV_ADDR, `DQU_CMD_SWRST, 4'h0, 16'h0000);
        chk_dacs("software reset");
        for (int i = 0; i < 4; i++) begin
            nxt(v);
            word(`DQU_DEV_ADDR, `DQU_CMD_WR_IN, 4'h1 << i, v);
        end
        set_ld(1'b0);
        set_ld(1'b1);
        chk_dacs("mask cleared");
        @(posedge clk) #1 sel = 1'b0;
        hr_n = 1'b0;
        clear_all();
        chk_dacs("hardware reset");
        nxt(v);
        word(`DQU_DEV_ADDR, `DQU_CMD_WR_UPD, 4'hF, v);
        chk_dacs("blocked while low");
        @(posedge clk) #1 hr_n = 1'b1;
        chk_dacs("held after release");
        give_verdict();
    end
endmodule : test_quad_dac_update_control
